/* hw/pin_sync.sv */
// Purpose: three-stage synchroniser with agreement filter
// Assumes: input from outside the clock domain
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module pin_sync (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_pin,
  input wire logic i_init,
  output logic o_level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } sync_t;
  sync_t st;
  sync_t next_st;
  always_comb begin
    next_st = st;
    next_st.s1 = i_pin;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // change accepted only once stages two and three agree
    if (st.s2 == st.s3) begin
      next_st.level = st.s3;
    end
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign o_level = st.level;
  // i_init unused by logic path; kept constant reset value of zero
  logic unused_init;
  assign unused_init = i_init;
endmodule

/* hw/scan_port.sv */
// Purpose: test access port with emulator lines and global output kill
// Assumes: test clock far slower than i_clk; edges found by sampling
// Notes: test reset low means functional mode
`timescale 1ns/1ps
// Summary of operation
// - capture mode and data on test clock rise
// - change test data out on falling edge
// - data out floats except while shifting
// - test reset high gives scan system control
// - test reset low ignores scan pins
// - emulator lines bidirectional under scan control
// - second line becomes output kill input
// - kill condition floats every output driver
module scan_port (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic i_tdi,
  input wire logic i_trst_n,
  input wire logic i_emulator_line_a,
  input wire logic i_emulator_line_b_or_output_kill,
  input wire logic i_core_drive_en,
  output logic o_tdo,
  output logic o_tdo_oe,
  output logic o_emulator_line_a,
  output logic o_emulator_line_a_oe,
  output logic o_emulator_line_b,
  output logic o_emulator_line_b_oe,
  output logic o_emu_irq_a,
  output logic o_emu_irq_b,
  output logic o_scan_mode,
  output logic o_outputs_enable
);
  logic tck_s, tms_s, tdi_s, trst_s, ea_s, eb_s;
  pin_sync u_tck (.i_clk(i_clk), .i_rst(i_rst), .i_pin(i_tck), .i_init(1'b0), .o_level(tck_s));
  pin_sync u_tms (.i_clk(i_clk), .i_rst(i_rst), .i_pin(i_tms), .i_init(1'b0), .o_level(tms_s));
  pin_sync u_tdi (.i_clk(i_clk), .i_rst(i_rst), .i_pin(i_tdi), .i_init(1'b0), .o_level(tdi_s));
  pin_sync u_trst (.i_clk(i_clk), .i_rst(i_rst), .i_pin(i_trst_n), .i_init(1'b0), .o_level(trst_s));
  pin_sync u_ea (.i_clk(i_clk), .i_rst(i_rst), .i_pin(i_emulator_line_a), .i_init(1'b0), .o_level(ea_s));
  pin_sync u_eb (.i_clk(i_clk), .i_rst(i_rst), .i_pin(i_emulator_line_b_or_output_kill), .i_init(1'b0),
    .o_level(eb_s));

  typedef struct packed {
    logic tck_d;
    scan_port_pkg::tap_state_t tap;
    logic [3:0] ir_sh;
    logic [3:0] ir;
    logic [3:0] dr_sh;
    logic [3:0] emu_ctl;
    logic bypass;
    logic tdo;
    logic tdo_oe;
    logic ea;
    logic ea_oe;
    logic eb;
    logic eb_oe;
    logic irq_a;
    logic irq_b;
    logic scan_mode;
    logic out_en;
  } port_t;
  port_t st;
  port_t next_st;

  function automatic scan_port_pkg::tap_state_t tap_next(input scan_port_pkg::tap_state_t s, input logic m);
    case (s)
      scan_port_pkg::TLR: tap_next = m ? scan_port_pkg::TLR : scan_port_pkg::RTI;
      scan_port_pkg::RTI: tap_next = m ? scan_port_pkg::SEL_DR : scan_port_pkg::RTI;
      scan_port_pkg::SEL_DR: tap_next = m ? scan_port_pkg::SEL_IR : scan_port_pkg::CAP_DR;
      scan_port_pkg::CAP_DR: tap_next = m ? scan_port_pkg::EX1_DR : scan_port_pkg::SH_DR;
      scan_port_pkg::SH_DR: tap_next = m ? scan_port_pkg::EX1_DR : scan_port_pkg::SH_DR;
      scan_port_pkg::EX1_DR: tap_next = m ? scan_port_pkg::UP_DR : scan_port_pkg::PA_DR;
      scan_port_pkg::PA_DR: tap_next = m ? scan_port_pkg::EX2_DR : scan_port_pkg::PA_DR;
      scan_port_pkg::EX2_DR: tap_next = m ? scan_port_pkg::UP_DR : scan_port_pkg::SH_DR;
      scan_port_pkg::UP_DR: tap_next = m ? scan_port_pkg::SEL_DR : scan_port_pkg::RTI;
      scan_port_pkg::SEL_IR: tap_next = m ? scan_port_pkg::TLR : scan_port_pkg::CAP_IR;
      scan_port_pkg::CAP_IR: tap_next = m ? scan_port_pkg::EX1_IR : scan_port_pkg::SH_IR;
      scan_port_pkg::SH_IR: tap_next = m ? scan_port_pkg::EX1_IR : scan_port_pkg::SH_IR;
      scan_port_pkg::EX1_IR: tap_next = m ? scan_port_pkg::UP_IR : scan_port_pkg::PA_IR;
      scan_port_pkg::PA_IR: tap_next = m ? scan_port_pkg::EX2_IR : scan_port_pkg::PA_IR;
      scan_port_pkg::EX2_IR: tap_next = m ? scan_port_pkg::UP_IR : scan_port_pkg::SH_IR;
      scan_port_pkg::UP_IR: tap_next = m ? scan_port_pkg::SEL_DR : scan_port_pkg::RTI;
      default: tap_next = scan_port_pkg::TLR;
    endcase
  endfunction

  logic rise, fall, kill, emu_sel;
  always_comb begin
    rise = tck_s && !st.tck_d;
    fall = !tck_s && st.tck_d;
    kill = !trst_s && ea_s && !eb_s;
    emu_sel = (st.ir == scan_port_pkg::IR_EMUCTL);
    next_st = st;
    next_st.tck_d = tck_s;
    if (!trst_s) begin
      // async-style reset of the controller while test reset is low
      next_st.tap = scan_port_pkg::TLR;
      next_st.ir = scan_port_pkg::IR_RESET;
      next_st.emu_ctl = scan_port_pkg::EMU_CTL_RESET;
      next_st.scan_mode = 1'b0;
    end else begin
      next_st.scan_mode = 1'b1;
      if (rise) begin
        next_st.tap = tap_next(st.tap, tms_s);
        case (st.tap)
          scan_port_pkg::CAP_IR: next_st.ir_sh = {2'h0, scan_port_pkg::IR_CAPTURE};
          scan_port_pkg::SH_IR: next_st.ir_sh = {tdi_s, st.ir_sh[3:1]};
          scan_port_pkg::CAP_DR: begin
            next_st.dr_sh = st.emu_ctl;
            next_st.bypass = 1'b0;
          end
          scan_port_pkg::SH_DR: begin
            next_st.dr_sh = {tdi_s, st.dr_sh[3:1]};
            next_st.bypass = tdi_s;
          end
          scan_port_pkg::UP_IR: next_st.ir = st.ir_sh;
          scan_port_pkg::UP_DR: if (emu_sel) next_st.emu_ctl = st.dr_sh;
          scan_port_pkg::TLR: next_st.ir = scan_port_pkg::IR_RESET;
          default: ;
        endcase
      end
      if (fall) begin
        // output moves only on the falling test clock edge
        next_st.tdo_oe = (st.tap == scan_port_pkg::SH_IR) || (st.tap == scan_port_pkg::SH_DR);
        if (st.tap == scan_port_pkg::SH_IR) next_st.tdo = st.ir_sh[0];
        else if (emu_sel) next_st.tdo = st.dr_sh[0];
        else next_st.tdo = st.bypass;
      end
    end
    if (!trst_s) next_st.tdo_oe = 1'b0;
    // emulator lines: direction and value set through the scan chain
    next_st.ea_oe = trst_s && st.emu_ctl[scan_port_pkg::EMU_A_DIR_BIT];
    next_st.eb_oe = trst_s && st.emu_ctl[scan_port_pkg::EMU_B_DIR_BIT];
    next_st.ea = st.emu_ctl[scan_port_pkg::EMU_A_OUT_BIT];
    next_st.eb = st.emu_ctl[scan_port_pkg::EMU_B_OUT_BIT];
    next_st.irq_a = trst_s && !st.emu_ctl[scan_port_pkg::EMU_A_DIR_BIT] && ea_s;
    next_st.irq_b = trst_s && !st.emu_ctl[scan_port_pkg::EMU_B_DIR_BIT] && eb_s;
    // kill needs line a high and line b low from the controller; no bus sharing use
    // core enable folded in before the register so the pin leaves a flip-flop; costs one clock
    next_st.out_en = !kill && i_core_drive_en;
    if (kill) begin
      next_st.tdo_oe = 1'b0;
      next_st.ea_oe = 1'b0;
      next_st.eb_oe = 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
      st.tap <= scan_port_pkg::TLR;
      st.ir <= scan_port_pkg::IR_RESET;
      st.out_en <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign o_tdo = st.tdo;
  assign o_tdo_oe = st.tdo_oe;
  assign o_emulator_line_a = st.ea;
  assign o_emulator_line_a_oe = st.ea_oe;
  assign o_emulator_line_b = st.eb;
  assign o_emulator_line_b_oe = st.eb_oe;
  assign o_emu_irq_a = st.irq_a;
  assign o_emu_irq_b = st.irq_b;
  assign o_scan_mode = st.scan_mode;
  assign o_outputs_enable = st.out_en;

  sequence s_kill_seen;
    kill;
  endsequence
  sequence s_all_float;
    !st.tdo_oe && !st.ea_oe && !st.eb_oe && !st.out_en;
  endsequence
  property p_kill_floats;
    @(posedge i_clk) disable iff (i_rst) s_kill_seen |=> s_all_float;
  endproperty
  a_kill_floats: assert property (p_kill_floats) else $error("driver on during kill");
  property p_tdo_fall_only;
    @(posedge i_clk) disable iff (i_rst) (trst_s && !fall) |=> $stable(st.tdo);
  endproperty
  a_tdo_fall_only: assert property (p_tdo_fall_only) else $error("tdo moved off falling edge");
  property p_tdo_float;
    @(posedge i_clk) disable iff (i_rst)
      (st.tap != scan_port_pkg::SH_IR && st.tap != scan_port_pkg::SH_DR && fall) |=> !st.tdo_oe;
  endproperty
  a_tdo_float: assert property (p_tdo_float) else $error("tdo driven outside shift");
  property p_trst_low;
    @(posedge i_clk) disable iff (i_rst) !trst_s |=> st.tap == scan_port_pkg::TLR && !st.scan_mode;
  endproperty
  a_trst_low: assert property (p_trst_low) else $error("controller not held in reset");
  property p_scan_mode;
    @(posedge i_clk) disable iff (i_rst) trst_s |=> st.scan_mode;
  endproperty
  a_scan_mode: assert property (p_scan_mode) else $error("scan mode not taken");
  property p_tap_step;
    @(posedge i_clk) disable iff (i_rst) (trst_s && rise) |=> st.tap == tap_next($past(st.tap), $past(tms_s));
  endproperty
  a_tap_step: assert property (p_tap_step) else $error("bad controller step");
  property p_tap_hold;
    @(posedge i_clk) disable iff (i_rst) (trst_s && !rise) |=> $stable(st.tap);
  endproperty
  a_tap_hold: assert property (p_tap_hold) else $error("controller moved without rise");
  property p_emu_dir;
    @(posedge i_clk) disable iff (i_rst)
      (trst_s && !kill && st.emu_ctl[scan_port_pkg::EMU_A_DIR_BIT]) |=> st.ea_oe;
  endproperty
  a_emu_dir: assert property (p_emu_dir) else $error("line a not driven");
  property p_kill_en;
    @(posedge i_clk) disable iff (i_rst)
      (!trst_s && !eb_s) |=> (st.out_en == (!$past(ea_s) && $past(i_core_drive_en)));
  endproperty
  a_kill_en: assert property (p_kill_en) else $error("kill enable wrong");
  property p_irq_func;
    @(posedge i_clk) disable iff (i_rst) !trst_s |=> !st.irq_a && !st.irq_b;
  endproperty
  a_irq_func: assert property (p_irq_func) else $error("emulator interrupt in functional mode");
  property p_emu_release;
    @(posedge i_clk) disable iff (i_rst) !trst_s |=> !st.ea_oe && !st.eb_oe;
  endproperty
  a_emu_release: assert property (p_emu_release) else $error("emulator line driven in functional mode");
endmodule

/* hw/scan_port_pkg.sv */
// Purpose: shared constants for the scan test port block
// Assumes: 200 MHz core clock samples the test clock and pins
// Notes: tap states one-hot, instruction codes local to this design
package scan_port_pkg;
  localparam int unsigned IR_WIDTH = 4;
  localparam int unsigned DR_BYPASS_WIDTH = 1;
  localparam int unsigned DR_EMU_WIDTH = 4;
  localparam logic [3:0] IR_RESET = 4'h1;
  localparam logic [3:0] IR_EMUCTL = 4'h8;
  localparam logic [3:0] IR_BYPASS = 4'hf;
  localparam logic [1:0] IR_CAPTURE = 2'h1;
  localparam int unsigned EMU_A_DIR_BIT = 0;
  localparam int unsigned EMU_B_DIR_BIT = 1;
  localparam int unsigned EMU_A_OUT_BIT = 2;
  localparam int unsigned EMU_B_OUT_BIT = 3;
  localparam logic [3:0] EMU_CTL_RESET = 4'h0;
  localparam int unsigned SYNC_DEPTH = 3;
  typedef enum logic [15:0] {
    TLR = 16'h0001, RTI = 16'h0002, SEL_DR = 16'h0004, CAP_DR = 16'h0008,
    SH_DR = 16'h0010, EX1_DR = 16'h0020, PA_DR = 16'h0040, EX2_DR = 16'h0080,
    UP_DR = 16'h0100, SEL_IR = 16'h0200, CAP_IR = 16'h0400, SH_IR = 16'h0800,
    EX1_IR = 16'h1000, PA_IR = 16'h2000, EX2_IR = 16'h4000, UP_IR = 16'h8000
  } tap_state_t;
endpackage

/* tb/scan_ctl_model.sv */
// Purpose: external scan controller driving the test clock, mode, data and test reset
// Assumes: test clock period 48 ns, stands still low between frames
// Notes: mode and data start at their pull-up level and then hold their last bit between cycles
`timescale 1ns/1ps
module scan_ctl_model (
  input wire logic i_tdo,
  input wire logic i_tdo_oe,
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  output logic o_trst_n
);
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b1;
    o_trst_n = 1'b0;
  end
  // one test clock; mode and data change just after the fall, so they stand 48 ns around the rise
  task automatic bit_cycle(input logic tms, input logic tdi, output logic tdo, output logic oe);
    o_tms = tms;
    o_tdi = tdi;
    #24 o_tck = 1'b1;
    // data out is taken late in the high phase, well after the previous fall
    // a floating data out reads as the inverse of its last value, so a stale bit cannot pass
    #20 tdo = i_tdo_oe ? i_tdo : ~i_tdo;
    oe = i_tdo_oe;
    #4 o_tck = 1'b0;
  endtask
  task automatic set_reset(input logic val);
    o_trst_n = val;
  endtask
endmodule

/* tb/scan_port_output_disable_test.sv */
// Purpose: self-checking bench for the scan port and output kill
// Assumes: sync latency about 4 clocks, outputs settle within 10
// Notes: emulator pins resolved from the block's enables and the bench's levels
`timescale 1ns/1ps
module scan_port_output_disable_test;
  logic i_clk, i_rst, drv_a, drv_b, core_en, pin_a, pin_b, t, oe;
  logic tck, tms, tdi, trst_n, tdo, tdo_oe, line_a, line_a_oe, line_b, line_b_oe;
  logic irq_a, irq_b, scan_mode, outs_en;
  logic [3:0] v, d, q;
  int n_fail, cmp_count;
  assign pin_a = line_a_oe ? line_a : drv_a;
  assign pin_b = line_b_oe ? line_b : drv_b;
  scan_port dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_tck(tck), .i_tms(tms), .i_tdi(tdi), .i_trst_n(trst_n),
    .i_emulator_line_a(pin_a), .i_emulator_line_b_or_output_kill(pin_b), .i_core_drive_en(core_en),
    .o_tdo(tdo), .o_tdo_oe(tdo_oe), .o_emulator_line_a(line_a), .o_emulator_line_a_oe(line_a_oe),
    .o_emulator_line_b(line_b), .o_emulator_line_b_oe(line_b_oe), .o_emu_irq_a(irq_a), .o_emu_irq_b(irq_b),
    .o_scan_mode(scan_mode), .o_outputs_enable(outs_en));
  scan_ctl_model ctl_u (.i_tdo(tdo), .i_tdo_oe(tdo_oe), .o_tck(tck), .o_tms(tms), .o_tdi(tdi), .o_trst_n(trst_n));
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  task automatic complete_run();
    if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input string name, input logic [3:0] exp, input logic [3:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      n_fail++;
    end
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // bounded wait: a test reset that never reaches the mode flag ends the run
  task automatic set_trst(input logic val);
    ctl_u.set_reset(val);
    for (int i = 0; i < 20 && scan_mode !== val; i++) @(negedge i_clk);
    check("scan_mode", val, scan_mode);
    if (scan_mode !== val) complete_run();
  endtask
  // walk from idle through capture and shift, four bits lsb first, back to idle
  task automatic shift(input logic ir, input logic [3:0] din, output logic [3:0] dout);
    dout = 4'h0;
    ctl_u.bit_cycle(1'b0, 1'b1, t, oe);
    ctl_u.bit_cycle(1'b1, 1'b1, t, oe);
    if (ir) ctl_u.bit_cycle(1'b1, 1'b1, t, oe);
    ctl_u.bit_cycle(1'b0, 1'b1, t, oe);
    ctl_u.bit_cycle(1'b0, 1'b1, t, oe);
    for (int i = 0; i < 4; i++) begin
      ctl_u.bit_cycle(i == 3, din[i], dout[i], oe);
      check("tdo_oe_shift", 4'h1, oe);
    end
    ctl_u.bit_cycle(1'b1, 1'b1, t, oe);
    check("tdo_oe_idle", 4'h0, oe);
    ctl_u.bit_cycle(1'b0, 1'b1, t, oe);
  endtask
  // every pin combination; the kill only counts in functional mode
  task automatic kill_table(input logic func);
    for (int k = 0; k < 8; k++) begin
      @(negedge i_clk);
      {drv_a, drv_b, core_en} = 3'(k);
      wait_clk(10);
      check("outputs_enable", core_en & ~(func & drv_a & ~drv_b), outs_en);
      if (func) check("tdo_oe_func", 4'h0, tdo_oe);
    end
    @(negedge i_clk) core_en = 1'b1;
  endtask
  initial begin
    void'($urandom(86));
    n_fail = 0;
    cmp_count = 0;
    i_rst = 1'b1;
    drv_a = 1'b0;
    drv_b = 1'b1;
    core_en = 1'b1;
    repeat (3) @(posedge i_clk);
    @(negedge i_clk) i_rst = 1'b0;
    wait_clk(8);
    check("scan_mode_reset", 4'h0, scan_mode);
    kill_table(1'b1);
    set_trst(1'b1);
    kill_table(1'b0);
    shift(1'b1, scan_port_pkg::IR_EMUCTL, q);
    check("ir_capture", scan_port_pkg::IR_CAPTURE, q[1:0]);
    v = 4'($urandom);
    @(negedge i_clk);
    drv_a = 1'($urandom);
    drv_b = 1'($urandom);
    shift(1'b0, v, q);
    check("emu_ctl_capture", scan_port_pkg::EMU_CTL_RESET, q);
    wait_clk(10);
    check("emu_oe_irq", {~v[1] & drv_b, ~v[0] & drv_a, v[1], v[0]}, {irq_b, irq_a, line_b_oe, line_a_oe});
    check("emu_value", {v[3] & v[1], v[2] & v[0]}, {line_b & v[1], line_a & v[0]});
    // test reset in mid-session: emulator lines released, scan pins ignored
    set_trst(1'b0);
    wait_clk(10);
    check("emu_released", 4'h0, {line_b_oe, line_a_oe});
    for (int i = 0; i < 6; i++) begin
      ctl_u.bit_cycle(i < 2, 1'b0, t, oe);
      check("tdo_oe_ignored", 4'h0, oe);
    end
    kill_table(1'b1);
    set_trst(1'b1);
    for (int k = 0; k < 3; k++) begin
      d = 4'($urandom);
      shift(1'b0, d, q);
      check("bypass", {d[2:0], 1'b0}, q);
    end
    complete_run();
  end
endmodule
